// >>> verilog/acd_pkg.sv
// Package for the serial command decoder: command codes, response prefixes,
// register addresses, reset values and timing counts.
// Assumes a single 40 MHz core clock.
package acd_pkg;
  // Command words
  localparam logic [15:0] CMD_NULL     = 16'h0000;
  localparam logic [15:0] CMD_RESET    = 16'h0011;
  localparam logic [15:0] CMD_STANDBY  = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP   = 16'h0033;
  localparam logic [15:0] CMD_LOCK     = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK   = 16'h0655;
  localparam logic [2:0]  PFX_RD       = 3'h1;
  localparam logic [2:0]  PFX_WR       = 3'h2;
  localparam logic [2:0]  PFX_WRM      = 3'h3;
  // Registers
  localparam logic [4:0]  ADDR_STATUS  = 5'h02;
  localparam logic [4:0]  ADDR_SYS_CFG = 5'h0B;
  localparam int          DLY_LSB      = 2;
  localparam logic [7:0]  REG_RST_VAL  = 8'h00;
  localparam logic [7:0]  READY_MSB    = 8'hFF;
  localparam logic [8:0]  REG_COUNT    = 9'h020;
  // Word size select
  localparam logic [1:0]  WSZ_16       = 2'h0;
  localparam logic [1:0]  WSZ_24       = 2'h1;
  // Pin sync vector reset: chip select idle high
  localparam logic [7:0]  SY_RST       = 8'h80;
  // Completion delay step
  localparam int          CLK_NS       = 25;
  localparam int          DONE_STEP_NS = 50;
  localparam int          DONE_STEP_CYC = (DONE_STEP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    K_NULL, K_RESET, K_STANDBY, K_WAKEUP, K_LOCK, K_UNLOCK,
    K_READ_SINGLE_REG_CMD, K_READ_MULTI_REG_CMD, K_WRITE_SINGLE_REG_CMD, K_WRITE_MULTI_REG_CMD, K_NONE
  } acd_cmd_e;

  typedef enum logic [1:0] {M_READY, M_OPEN, M_LOCKED} acd_mode_e;

  // Classifies a 16-bit command word into one of the ten commands, or K_NONE if none matches
  function automatic acd_cmd_e acd_kind(input logic [15:0] c);
    acd_cmd_e k;
    k = K_NONE;
    case (c)
      CMD_NULL:    k = K_NULL;
      CMD_RESET:   k = K_RESET;
      CMD_STANDBY: k = K_STANDBY;
      CMD_WAKEUP:  k = K_WAKEUP;
      CMD_LOCK:    k = K_LOCK;
      CMD_UNLOCK:  k = K_UNLOCK;
      default: begin
        if (c[15:13] == PFX_RD) k = (c[7:0] == 8'h00) ? K_READ_SINGLE_REG_CMD : K_READ_MULTI_REG_CMD;
        else if (c[15:13] == PFX_WR) k = K_WRITE_SINGLE_REG_CMD;
        else if (c[15:13] == PFX_WRM) k = K_WRITE_MULTI_REG_CMD;
      end
    endcase
    return k;
  endfunction
endpackage

// >>> verilog/acd_spi_cmd_decoder.sv
// Serial frame command decoder, response generator and frame-complete output.
// Assumes chip select, serial clock, data in and the frame straps arrive from
// pins outside the core clock domain; core_clk is much faster than the serial clock.
// Contract
// [R1] Frame-complete goes low after last bit, delayed
// [R2] Frame-complete drives next converter's chip select
// [R3] Ten 16-bit commands in first word
// [R4] Host zero-fills low bits of wide words
// [R5] Decode and apply command at frame end
// [R6] Recognized command answered in next frame
// [R7] Standby command stops conversions, echoes 0022h
// [R8] Wakeup command resumes, echoes 0033h
// [R9] Lock ignores all but poll, reads, unlock
// [R10] Unlock leaves locked or ready state
// [R11] Single read returns register data response
// [R12] Multi read returns n+1 consecutive registers
// [R13] Single write answers updated register contents
// [R14] Multi write takes pairs, acknowledges 010 form
// [R15] Multi write frame lengthened by n/2 words
// [R16] Response in upper 16 bits of word0
// [R17] Low bits of response word are zero
// [R18] Null command returns status register readback
// [R19] Software reset restores defaults, enters ready
// [R20] Commands ignored while multi read outputs
// [R21] Ready word FFh plus identifier; unlock only
`timescale 1ns/1ps
`default_nettype none
module acd_spi_cmd_decoder #(
  parameter logic [7:0] DEVICE_ID = 8'hA5  // Arbitrary identifier value
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Serial pins
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       din,
  output logic            dout,
  output logic            dout_oe,
  output logic            done_n,
  // Frame straps
  input  wire logic [1:0] word_size_sel,
  input  wire logic [2:0] frame_words,
  // Status
  output logic            standby
);
  import acd_pkg::*;

  typedef struct packed {
    logic [7:0]        sy1;
    logic [7:0]        sy2;
    logic              cs_d;
    logic              sclk_d;
    acd_mode_e         mode;
    logic              standby;
    logic [31:0][7:0]  regs;
    logic [255:0][7:0] wbuf;
    logic [31:0]       rx_sh;
    logic [5:0]        rx_bit;
    logic [7:0]        rx_word;
    logic [15:0]       cmd;
    logic              cmd_ok;
    logic [31:0]       tx_sh;
    logic [5:0]        tx_bit;
    logic [15:0]       resp;
    logic [8:0]        rd_ptr;
    logic [8:0]        rd_left;
    logic              rd_go;
    logic              oe;
    logic              fin;
    logic              done_r;
    logic              dly_run;
    logic [4:0]        dly_cnt;
    logic              apply;
    logic [4:0]        ap_base;
    logic [7:0]        ap_idx;
    logic [7:0]        ap_n;
  } acd_st_s;

  acd_st_s     st;
  acd_st_s     st_nxt;
  logic        cs_s;
  logic        sck_s;
  logic        din_s;
  logic        fstart;
  logic        fend;
  logic        rise;
  logic        fall;
  acd_cmd_e    kind;
  logic [15:0] ready_word;
  logic [15:0] readback;

  assign cs_s       = st.sy2[7];
  assign sck_s      = st.sy2[6];
  assign din_s      = st.sy2[5];
  assign fstart     = st.cs_d && !cs_s;
  assign fend       = !st.cs_d && cs_s;
  assign rise       = !cs_s && sck_s && !st.sclk_d;
  assign fall       = !cs_s && !sck_s && st.sclk_d;
  assign kind       = acd_kind(st.cmd);
  assign ready_word = {READY_MSB, DEVICE_ID};
  assign readback   = {PFX_RD, ADDR_STATUS, st.regs[ADDR_STATUS]};

  // Register read; addresses past the register space read as zero
  function automatic logic [7:0] rbyte(input logic [8:0] ad);
    return (ad < REG_COUNT) ? st.regs[ad[4:0]] : 8'h00;
  endfunction

  always_comb begin
    logic [5:0]  wbits;
    logic [31:0] w;
    logic [15:0] cmd_now;
    logic [6:0]  ext;
    logic [7:0]  total;
    logic [8:0]  bidx;
    logic [8:0]  aad;
    logic        ld_data;
    logic        allowed;
    logic        last_wd;
    acd_cmd_e    k_now;
    wbits   = 6'h20;
    w       = 32'h0000_0000;
    cmd_now = st.cmd;
    ext     = 7'h00;
    total   = 8'h00;
    bidx    = 9'h000;
    aad     = 9'h000;
    ld_data = 1'b0;
    allowed = 1'b0;
    last_wd = 1'b0;
    k_now   = K_NONE;
    st_nxt  = st;
    st_nxt.sy1    = {cs_n, sclk, din, word_size_sel, frame_words};
    st_nxt.sy2    = st.sy1;
    st_nxt.cs_d   = cs_s;
    st_nxt.sclk_d = sck_s;
    if (st.sy2[4:3] == WSZ_16) wbits = 6'h10;
    else if (st.sy2[4:3] == WSZ_24) wbits = 6'h18;

    // Frame start: load the response word, or continue a pending multi read
    if (fstart) begin
      st_nxt.tx_sh   = {st.resp, 16'h0000};                       // [R16] [R17]
      st_nxt.tx_bit  = 6'h00;
      st_nxt.rx_bit  = 6'h00;
      st_nxt.rx_word = 8'h00;
      st_nxt.cmd_ok  = 1'b0;
      st_nxt.oe      = 1'b1;
      st_nxt.fin     = 1'b0;
      st_nxt.done_r  = 1'b1;
      st_nxt.dly_run = 1'b0;
      ld_data        = st.rd_go && (st.rd_left != 9'h000);        // [R20]
      if (st.rd_left != 9'h000) st_nxt.rd_go = 1'b1;
    end

    // Last word of the frame: a stream word loaded here would never be sent
    last_wd = ({1'b0, st.rx_word} + 9'h001)
              >= ({6'h00, st.sy2[2:0]}
                  + ((st.rx_word != 8'h00 && kind == K_WRITE_MULTI_REG_CMD) ? {2'b00, st.cmd[7:1]} : 9'h000));

    // Output side: shift on serial clock rising edge
    if (rise && st.oe) begin
      if (st.tx_bit == wbits - 6'h01) begin
        st_nxt.tx_bit = 6'h00;
        st_nxt.tx_sh  = 32'h0000_0000;
        ld_data       = st.rd_go && (st.rd_left != 9'h000) && !last_wd;  // [R12] [R20]
      end else begin
        st_nxt.tx_bit = st.tx_bit + 6'h01;
        st_nxt.tx_sh  = {st.tx_sh[30:0], 1'b0};
      end
    end
    if (ld_data) begin
      st_nxt.tx_sh   = {rbyte(st.rd_ptr),
                        (st.rd_left > 9'h001) ? rbyte(st.rd_ptr + 9'h001) : 8'h00,
                        16'h0000};                                // [R12]
      st_nxt.rd_ptr  = st.rd_ptr + 9'h002;
      st_nxt.rd_left = (st.rd_left > 9'h001) ? st.rd_left - 9'h002 : 9'h000;
    end

    // Input side: sample on serial clock falling edge
    if (fall && !st.fin) begin
      st_nxt.rx_sh = {st.rx_sh[30:0], din_s};
      if (st.rx_bit == wbits - 6'h01) begin
        st_nxt.rx_bit = 6'h00;
        w = st_nxt.rx_sh << (6'h20 - wbits);
        if (st.rx_word == 8'h00) begin
          cmd_now       = w[31:16];                               // [R3] [R4]
          st_nxt.cmd    = cmd_now;
          st_nxt.cmd_ok = 1'b1;
        end else if (acd_kind(st.cmd) == K_WRITE_MULTI_REG_CMD) begin
          bidx = {st.rx_word, 1'b0} - 9'h002;                     // [R14]
          if (bidx <= {1'b0, st.cmd[7:0]}) st_nxt.wbuf[bidx[7:0]] = w[31:24];
          if (bidx < {1'b0, st.cmd[7:0]}) st_nxt.wbuf[bidx[7:0] + 8'h01] = w[23:16];
        end
        if (acd_kind(cmd_now) == K_WRITE_MULTI_REG_CMD) ext = cmd_now[7:1];     // [R15]
        total = {5'h00, st.sy2[2:0]} + {1'b0, ext};
        st_nxt.rx_word = st.rx_word + 8'h01;
        if (st.rx_word + 8'h01 == total) begin
          st_nxt.fin     = 1'b1;
          st_nxt.oe      = 1'b0;
          st_nxt.dly_run = 1'b1;                                  // [R1]
          st_nxt.dly_cnt = 5'(({30'h0, st.regs[ADDR_SYS_CFG][DLY_LSB +: 2]} + 32'h1)
                              * DONE_STEP_CYC - 1);
        end
      end else begin
        st_nxt.rx_bit = st.rx_bit + 6'h01;
      end
    end

    // Completion delay then frame-complete low
    if (st.dly_run) begin
      if (st.dly_cnt == 5'h00) begin
        st_nxt.done_r  = 1'b0;                                    // [R1] [R2]
        st_nxt.dly_run = 1'b0;
      end else begin
        st_nxt.dly_cnt = st.dly_cnt - 5'h01;
      end
    end

    // Staged multi write copied into the register file
    if (st.apply) begin
      aad = {4'h0, st.ap_base} + {1'b0, st.ap_idx};
      if (aad < REG_COUNT) st_nxt.regs[aad[4:0]] = st.wbuf[st.ap_idx];  // [R14]
      if (st.ap_idx == st.ap_n) st_nxt.apply = 1'b0;
      else st_nxt.ap_idx = st.ap_idx + 8'h01;
    end

    // Frame end: decode the received command
    if (fend) begin
      st_nxt.oe      = 1'b0;
      st_nxt.done_r  = 1'b1;
      st_nxt.dly_run = 1'b0;
      k_now   = kind;
      allowed = (st.mode == M_OPEN) || (k_now == K_NULL) || (k_now == K_UNLOCK)
                || (k_now == K_READ_SINGLE_REG_CMD) || (k_now == K_READ_MULTI_REG_CMD);       // [R9]
      if (st.cmd_ok && st.rd_left == 9'h000 && !st.apply) begin   // [R5] [R20]
        case (st.mode)
          M_READY: begin
            if (k_now == K_UNLOCK) begin                          // [R10] [R21]
              st_nxt.mode = M_OPEN;
              st_nxt.resp = st.cmd;
            end else begin
              st_nxt.resp = ready_word;                           // [R21]
            end
          end
          M_OPEN, M_LOCKED: begin
            if (!allowed) begin
              st_nxt.resp = readback;                             // [R9]
            end else begin
              case (k_now)
                K_RESET: begin                                    // [R19]
                  st_nxt.regs    = {32{REG_RST_VAL}};
                  st_nxt.mode    = M_READY;
                  st_nxt.standby = 1'b0;
                  st_nxt.resp    = ready_word;
                end
                K_STANDBY: begin                                  // [R7]
                  st_nxt.standby = 1'b1;
                  st_nxt.resp    = st.cmd;
                end
                K_WAKEUP: begin                                   // [R8]
                  st_nxt.standby = 1'b0;
                  st_nxt.resp    = st.cmd;
                end
                K_LOCK: begin                                     // [R9]
                  st_nxt.mode = M_LOCKED;
                  st_nxt.resp = st.cmd;
                end
                K_UNLOCK: begin                                   // [R10]
                  st_nxt.mode = M_OPEN;
                  st_nxt.resp = st.cmd;
                end
                K_READ_SINGLE_REG_CMD: begin                                     // [R11] [R6]
                  st_nxt.resp = {PFX_RD, st.cmd[12:8], rbyte({4'h0, st.cmd[12:8]})};
                end
                K_READ_MULTI_REG_CMD: begin                                    // [R12]
                  st_nxt.resp    = {PFX_WRM, st.cmd[12:0]};
                  st_nxt.rd_ptr  = {4'h0, st.cmd[12:8]};
                  st_nxt.rd_left = {1'b0, st.cmd[7:0]} + 9'h001;
                  st_nxt.rd_go   = 1'b0;
                end
                K_WRITE_SINGLE_REG_CMD: begin                                     // [R13]
                  st_nxt.regs[st.cmd[12:8]] = st.cmd[7:0];
                  st_nxt.resp = {PFX_RD, st.cmd[12:0]};
                end
                K_WRITE_MULTI_REG_CMD: begin                                    // [R14]
                  st_nxt.resp    = {PFX_WR, st.cmd[12:0]};
                  st_nxt.apply   = 1'b1;
                  st_nxt.ap_base = st.cmd[12:8];
                  st_nxt.ap_idx  = 8'h00;
                  st_nxt.ap_n    = st.cmd[7:0];
                end
                default: st_nxt.resp = readback;                  // [R18]
              endcase
            end
          end
          default: st_nxt.mode = M_READY;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.sy1    <= SY_RST;
      st.sy2    <= SY_RST;
      st.cs_d   <= 1'b1;
      st.mode   <= M_READY;
      st.regs   <= {32{REG_RST_VAL}};
      st.resp   <= {READY_MSB, DEVICE_ID};
      st.done_r <= 1'b1;
    end else begin
      st <= st_nxt;
    end
  end

  assign dout    = st.tx_sh[31];
  assign dout_oe = st.oe;
  assign done_n  = st.done_r;
  assign standby = st.standby;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_frame_end;
    fend && st.cmd_ok && st.rd_left == 9'h000 && !st.apply;
  endsequence
  sequence s_frame_start;
    fstart;
  endsequence

  a_done_after_last: assert property ($rose(st.dly_run) |-> ##[1:9] (!done_n || cs_s)) // [R1]
    else $error("frame-complete not asserted after last bit");
  a_done_idle_high: assert property (fend |=> done_n [*2]) // [R1]
    else $error("frame-complete low outside a frame");
  a_standby_echo: assert property (s_frame_end ##0 (kind == K_STANDBY && st.mode == M_OPEN)
    |=> standby && st.resp == CMD_STANDBY) // [R7]
    else $error("standby not entered or not echoed");
  a_wakeup_echo: assert property (s_frame_end ##0 (kind == K_WAKEUP && st.mode == M_OPEN)
    |=> !standby && st.resp == CMD_WAKEUP) // [R8]
    else $error("wakeup not applied or not echoed");
  a_lock_blocks_wr: assert property (s_frame_end ##0 (st.mode == M_LOCKED && kind == K_WRITE_SINGLE_REG_CMD)
    |=> $stable(st.regs) && st.resp == readback) // [R9]
    else $error("write accepted while locked");
  a_unlock_opens: assert property (s_frame_end ##0 (kind == K_UNLOCK)
    |=> st.mode == M_OPEN && st.resp == CMD_UNLOCK) // [R10]
    else $error("unlock not applied");
  a_read_single_reg_cmd_resp: assert property (s_frame_end ##0 (kind == K_READ_SINGLE_REG_CMD && st.mode != M_READY)
    |=> st.resp[15:13] == PFX_RD && st.resp[7:0] == $past(rbyte({4'h0, st.cmd[12:8]}))) // [R11]
    else $error("single read response wrong");
  a_null_status: assert property (s_frame_end ##0 (kind == K_NULL && st.mode != M_READY)
    |=> st.resp == {PFX_RD, ADDR_STATUS, st.regs[ADDR_STATUS]}) // [R18]
    else $error("null command response is not status readback");
  a_reset_ready: assert property (s_frame_end ##0 (kind == K_RESET && st.mode == M_OPEN)
    |=> st.mode == M_READY && st.resp == ready_word && st.regs == {32{REG_RST_VAL}}) // [R19]
    else $error("software reset incomplete");
  a_ready_only_unlock: assert property (s_frame_end ##0 (st.mode == M_READY && kind != K_UNLOCK)
    |=> st.mode == M_READY && st.resp == ready_word) // [R21]
    else $error("command accepted before unlock");
  a_read_multi_reg_cmd_busy: assert property ((fend && st.rd_left != 9'h000) |=> $stable(st.resp)) // [R20]
    else $error("command taken during multi read output");
  a_resp_word0: assert property ((s_frame_start ##0 st.rd_left == 9'h000)
    |=> st.tx_sh == {$past(st.resp), 16'h0000} && dout_oe) // [R16] [R17]
    else $error("first word does not carry the response");
endmodule
`default_nettype wire

// >>> test/acd_host_model.sv
// Host side serial master model for the command decoder.
// Assumes core_clk at 40 MHz and a device that samples its pins through synchronizers.
`timescale 1ns/1ps
`default_nettype none
module acd_host_model (
  // Clock
  input  wire logic        core_clk,
  // Serial pins
  output logic             cs_n,
  output logic             sclk,
  output logic             din,
  input  wire logic        dout,
  input  wire logic        dout_oe,
  input  wire logic        done_n,
  // Captured frame
  output logic [63:0]      rx,
  output logic [7:0]       rx_bits,
  output logic [7:0]       done_cyc,
  output logic             rx_valid
);
  localparam int PH = 6;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    rx = '0;
    rx_bits = '0;
    done_cyc = '0;
    rx_valid = 1'b0;
  end

  // One frame of nb bits; clock stands low outside frames
  task automatic frame(input logic [63:0] tx, input int nb, input bit chk);
    int k;
    @(posedge core_clk);
    cs_n <= 1'b0;
    rx <= '0;
    rx_bits <= '0;
    repeat (PH) @(posedge core_clk);
    for (k = 0; k < nb; k++) begin
      // Each output bit stands before the rising edge that advances it
      if (dout_oe === 1'b1) begin
        rx <= {rx[62:0], dout};
        rx_bits <= rx_bits + 8'd1;
      end
      sclk <= 1'b1;
      din <= tx[63-k];
      repeat (PH) @(posedge core_clk);
      sclk <= 1'b0;
      repeat (PH) @(posedge core_clk);
    end
    // Completion line acts as the next device's select
    for (k = 0; k < 60; k++) begin
      if (done_n === 1'b0) break;
      @(posedge core_clk);
    end
    done_cyc <= (dout_oe === 1'b0) ? 8'(k + PH) : 8'hFE;
    repeat (3) @(posedge core_clk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (8) @(posedge core_clk);
    rx_valid <= chk;
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_adc_spi_command_decoder.sv
// Testbench for the serial command decoder: the host model sends command frames,
// a watcher compares each captured response with the oldest noted expectation.
// Assumes each response appears in word 0 of the frame after its command.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_spi_command_decoder;
  import acd_pkg::*;
  typedef struct packed {
    logic [1:0]  sel;
    logic [7:0]  nb;
    logic [7:0]  wd;
    logic [31:0] val;
  } acd_note_s;
  localparam logic [7:0] ID = 8'hA5;  // Arbitrary identifier value
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sclk, din, dout, dout_oe, done_n, standby, rx_valid;
  logic [1:0]  word_size_sel = WSZ_16;
  logic [2:0]  frame_words = 3'd1;
  logic [63:0] rx;
  logic [7:0]  rx_bits, done_cyc, d0, d1, d2, dr;
  logic [15:0] rdy, st;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cur_sel = 0;
  int          lo;
  acd_note_s   notes[$];
  acd_note_s   nt;

  always #12.5 core_clk = ~core_clk;

  acd_spi_cmd_decoder #(.DEVICE_ID(ID)) acd_spi_cmd_decoder_i (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe), .done_n(done_n), .word_size_sel(word_size_sel),
    .frame_words(frame_words), .standby(standby));
  acd_host_model acd_host_model_i (
    .core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .done_n(done_n), .rx(rx), .rx_bits(rx_bits),
    .done_cyc(done_cyc), .rx_valid(rx_valid));

  function automatic logic [15:0] w(input logic [2:0] p, input logic [4:0] a,
                                    input logic [7:0] d);
    return {p, a, d};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic xfer(input logic [15:0] cmd, input logic [47:0] ext, input int nb,
                      input logic [31:0] ev, input int wd, input bit ck);
    if (ck) notes.push_back('{cur_sel[1:0], nb[7:0], wd[7:0], ev});
    acd_host_model_i.frame({cmd, ext}, nb, ck);
  endtask

  task automatic straps(input logic [1:0] ws, input logic [2:0] fw);
    @(posedge core_clk);
    word_size_sel <= ws;
    frame_words <= fw;
    repeat (4) @(posedge core_clk);
  endtask

  // Watcher: takes the oldest note whenever a frame result appears
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1) begin
      if (notes.size() == 0) chk(64'd1, 64'd0);
      else begin
        nt = notes.pop_front();
        lo = (int'(nt.sel) + 1) * 2 + 3;
        chk({56'd0, rx_bits}, {56'd0, nt.nb});
        chk(rx >> (int'(rx_bits) - int'(nt.wd)), {32'd0, nt.val});
        chk({63'd0, done_cyc >= 8'(lo) && done_cyc <= 8'(lo + 3)}, 64'd1);
      end
    end
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    results();
  end

  initial begin
    void'($urandom(32'haaa1c3b3));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    dr = 8'($urandom) | 8'h01;
    rdy = {READY_MSB, ID};
    st = w(PFX_RD, ADDR_STATUS, REG_RST_VAL);
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    xfer(CMD_NULL, 48'd0, 16, rdy, 16, 1'b1);
    xfer(w(PFX_WR, ADDR_SYS_CFG, 8'h0C), 48'd0, 16, rdy, 16, 1'b1);
    xfer(CMD_UNLOCK, 48'd0, 16, rdy, 16, 1'b1);
    xfer(w(PFX_WR, ADDR_SYS_CFG, 8'h0C), 48'd0, 16, CMD_UNLOCK, 16, 1'b1);
    cur_sel = 3;
    xfer(w(PFX_RD, ADDR_SYS_CFG, 8'h00), 48'd0, 16, w(PFX_RD, ADDR_SYS_CFG, 8'h0C), 16, 1'b1);
    xfer(CMD_STANDBY, 48'd0, 16, w(PFX_RD, ADDR_SYS_CFG, 8'h0C), 16, 1'b1);
    chk({63'd0, standby}, 64'd1);
    xfer(CMD_WAKEUP, 48'd0, 16, CMD_STANDBY, 16, 1'b1);
    chk({63'd0, standby}, 64'd0);
    xfer(CMD_NULL, 48'd0, 16, CMD_WAKEUP, 16, 1'b1);
    xfer(CMD_LOCK, 48'd0, 16, st, 16, 1'b1);
    xfer(w(PFX_WR, 5'h05, dr), 48'd0, 16, CMD_LOCK, 16, 1'b1);
    xfer(w(PFX_RD, 5'h05, 8'h00), 48'd0, 16, st, 16, 1'b1);
    xfer(CMD_STANDBY, 48'd0, 16, w(PFX_RD, 5'h05, REG_RST_VAL), 16, 1'b1);
    xfer(CMD_UNLOCK, 48'd0, 16, st, 16, 1'b1);
    chk({63'd0, standby}, 64'd0);
    xfer(16'h8000, 48'd0, 16, CMD_UNLOCK, 16, 1'b1);
    straps(WSZ_24, 3'd1);
    xfer(CMD_NULL, 48'd0, 24, {8'd0, st, 8'h00}, 24, 1'b1);
    straps(2'h2, 3'd1);
    xfer(CMD_NULL, 48'd0, 32, {st, 16'h0000}, 32, 1'b1);
    straps(WSZ_16, 3'd2);
    xfer(w(PFX_WRM, 5'h10, 8'h02), {d0, d1, d2, 24'd0}, 48, st, 16, 1'b1);
    xfer(w(PFX_RD, 5'h10, 8'h01), 48'd0, 32, w(PFX_WR, 5'h10, 8'h02), 16, 1'b1);
    xfer(CMD_NULL, 48'd0, 32, {w(PFX_WRM, 5'h10, 8'h01), d0, d1}, 32, 1'b1);
    xfer(w(PFX_RD, 5'h12, 8'h00), 48'd0, 32, 32'd0, 16, 1'b0);
    straps(WSZ_16, 3'd1);
    xfer(w(PFX_RD, 5'h10, 8'h03), 48'd0, 16, w(PFX_RD, 5'h12, d2), 16, 1'b1);
    xfer(CMD_STANDBY, 48'd0, 16, w(PFX_WRM, 5'h10, 8'h03), 16, 1'b1);
    xfer(CMD_NULL, 48'd0, 16, {d0, d1}, 16, 1'b1);
    chk({63'd0, standby}, 64'd0);
    xfer(CMD_NULL, 48'd0, 16, {d2, REG_RST_VAL}, 16, 1'b1);
    xfer(CMD_RESET, 48'd0, 16, st, 16, 1'b1);
    cur_sel = 0;
    xfer(CMD_NULL, 48'd0, 16, rdy, 16, 1'b1);
    xfer(CMD_UNLOCK, 48'd0, 16, rdy, 16, 1'b1);
    xfer(w(PFX_RD, ADDR_SYS_CFG, 8'h00), 48'd0, 16, CMD_UNLOCK, 16, 1'b1);
    xfer(CMD_NULL, 48'd0, 16, w(PFX_RD, ADDR_SYS_CFG, REG_RST_VAL), 16, 1'b1);
    repeat (4) @(posedge core_clk);
    results();
  end
endmodule
`default_nettype wire
